// ===== verilog/host_bus_dma_glue_defs.vh
`ifndef HOST_BUS_DMA_GLUE_DEFS_VH
`define HOST_BUS_DMA_GLUE_DEFS_VH

// Wishbone byte offsets of the controller's registers and its memory window.
`define OFS_CTRL       12'h000
`define OFS_REG_CMD    12'h004
`define OFS_STATUS     12'h008
`define OFS_MEM_BASE   12'h400
`define OFS_MEM_MASK   12'hc00

// Control register fields.
`define CTRL_FAST_BIT  0
`define CTRL_LOOP_BIT  1
`define CTRL_DMAEN_BIT 2
`define CTRL_RESET     3'h0

// Register command fields: data, index, read flag.
`define CMD_DATA_LSB   0
`define CMD_INDEX_LSB  8
`define CMD_READ_BIT   12

// Status register fields.
`define ST_BUSY_BIT    0
`define ST_RDATA_LSB   8
`define ST_GRANT_BIT   16
`define ST_ACK_BIT     17
`define ST_DIR_BIT     18

// Timing.
`define CLK_MHZ        100
`define CPU_HALF_CYC   4'h4
`define STROBE_NS      100
`define SETUP_NS       30

`endif

// ===== verilog/host_bus_dma_glue.v
// Overview of operation
// - Host drives index, select, one strobe first.
// - Software readies transmit data before buffer-ready.
// - Software reserves receive memory before receive-ready.
// - Processor floats its bus during device ownership.
// - Transceivers reversed only on reads, DMA Out.
// - Latches drive when device owns; capture on In.
// - Processor samples request, floats, asserts grant.
// - Glue drives acknowledge low after delayed grant.
// - DMA In: output enable, capture, ack release.
// - Request release one interface cycle later when fast.
// - Grant and output enable drop on falling edge.
// - DMA Out write enable for one interface cycle.
// - Grant returns high at next falling clock edge.
// - Memory strobes active only for matching cycles.
// - Delayed grant lags grant one cycle falling; in fast mode the lag is half or one interface cycle.
// - Second and third request stages lag release.
// - Interface clock is processor clock or half.
// - Loop control blocks modem RTS, loops to CTS.
// - Fast mode picks half clock and third stage.
`default_nettype none
`include "host_bus_dma_glue_defs.vh"

module host_bus_dma_glue (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        ce_in,
	input  wire        wb_cyc_in,
	input  wire        wb_stb_in,
	input  wire        wb_we_in,
	input  wire [11:0] wb_adr_in,
	input  wire [3:0]  wb_sel_in,
	input  wire [31:0] wb_dat_in,
	output reg  [31:0] wb_dat_out,
	output reg         wb_ack_out,
	input  wire [7:0]  cpu_data_lines_in,
	output reg  [7:0]  cpu_data_lines_out,
	output reg         cpu_data_lines_oe_n_out,
	output reg  [3:0]  reg_index_lines_out,
	output reg         dev_select_n_out,
	output reg         reg_write_strobe_n_out,
	output reg         reg_read_strobe_n_out,
	input  wire        dma_request_n_in,
	input  wire        dma_out_dir_in,
	input  wire [15:0] dma_addr_lines_in,
	output reg         dma_ack_n_out,
	output reg         cpu_bus_request_n_out,
	output reg         cpu_bus_grant_n_out,
	output reg         grant_delayed_n_out,
	output reg         request_stage1_n_out,
	output reg         request_stage2_n_out,
	output reg         request_stage3_n_out,
	output reg         mem_output_en_n_out,
	output reg         mem_write_en_n_out,
	output reg         mem_decode_en_n_out,
	output reg         dma_mem_read_strobe_n_out,
	output reg         addr_latch_drive_n_out,
	output reg         xcvr_toward_cpu_n_out,
	output reg         internal_loop_ctl_out,
	output reg         cpu_clk_out,
	output reg         half_cpu_clk_out,
	output reg         if_clk_out,
	input  wire        dev_rts_n_in,
	input  wire        modem_cts_n_in,
	output reg         modem_rts_n_out,
	output reg         dev_cts_n_out
);

	// Cycle counts from the strobe and setup times, rounded up.
	localparam integer STROBE_I   = (`STROBE_NS * `CLK_MHZ + 999) / 1000;
	localparam integer SETUP_I    = (`SETUP_NS * `CLK_MHZ + 999) / 1000;
	localparam [7:0]   STROBE_CYC = STROBE_I[7:0];
	localparam [7:0]   SETUP_CYC  = SETUP_I[7:0];

	// Processor bus ownership states.
	localparam [1:0] C_RUN  = 2'h0;
	localparam [1:0] C_SEEN = 2'h1;
	localparam [1:0] C_HELD = 2'h2;
	localparam [1:0] C_REL  = 2'h3;

	// DMA glue states.
	localparam [2:0] D_IDLE = 3'h0;
	localparam [2:0] D_ACK  = 3'h1;
	localparam [2:0] D_IN   = 3'h2;
	localparam [2:0] D_WR   = 3'h3;
	localparam [2:0] D_END  = 3'h4;
	localparam [2:0] D_DONE = 3'h5;

	// Register access states.
	localparam [1:0] R_IDLE  = 2'h0;
	localparam [1:0] R_SETUP = 2'h1;
	localparam [1:0] R_STRB  = 2'h2;
	localparam [1:0] R_HOLD  = 2'h3;

	// Filter for pin inputs: accept a value once stages two and three agree.
	function [27:0] settle;
		input [27:0] s2;
		input [27:0] s3;
		input [27:0] old;
		integer i;
		begin
			for (i = 0; i < 28; i = i + 1)
				settle[i] = (s2[i] == s3[i]) ? s3[i] : old[i];
		end
	endfunction

	reg  [27:0] sync1_q;
	reg  [27:0] sync2_q;
	reg  [27:0] sync3_q;
	reg  [27:0] pin_q;
	reg  [2:0]  ctrl_q;
	reg  [12:0] cmd_q;
	reg         cmd_pend_q;
	reg  [7:0]  rdata_q;
	reg  [3:0]  div_q;
	reg  [1:0]  cst_q;
	reg  [2:0]  dst_q;
	reg  [1:0]  rst_q;
	reg  [7:0]  rcnt_q;
	reg  [15:0] addr_cap_q;
	reg  [7:0]  mem_q [0:255];

	wire        drq_s   = pin_q[0];
	wire        dir_s   = pin_q[1];
	wire        rts_s   = pin_q[2];
	wire [15:0] addr_s  = pin_q[18:3];
	wire [7:0]  data_s  = pin_q[26:19];
	wire        cts_s   = pin_q[27];
	wire        fast    = ctrl_q[`CTRL_FAST_BIT];
	wire        wrap    = (div_q == `CPU_HALF_CYC - 4'h1);
	wire        cpu_ris = wrap & ~cpu_clk_out;
	wire        cpu_fal = wrap & cpu_clk_out;
	// Interface clock edges: processor clock or its half.
	wire        if_ris  = fast ? (cpu_ris & ~half_cpu_clk_out)
			: cpu_ris;
	wire        if_fal  = fast ? (cpu_ris & half_cpu_clk_out)
			: cpu_fal;
	wire        wb_req  = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	wire        is_mem  = (wb_adr_in & `OFS_MEM_MASK) == `OFS_MEM_BASE;
	wire [7:0]  mem_idx = wb_adr_in[9:2];
	wire        owned   = ~cpu_bus_grant_n_out;

	// Pin synchronisers, three stages each.
	always @(posedge clk_in) begin
		if (rst_in) begin
			sync1_q <= 28'hfffffff;
			sync2_q <= 28'hfffffff;
			sync3_q <= 28'hfffffff;
			pin_q   <= 28'hfffffff;
		end else if (ce_in) begin
			sync1_q <= {modem_cts_n_in, cpu_data_lines_in, dma_addr_lines_in,
				dev_rts_n_in, dma_out_dir_in, dma_request_n_in};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_q   <= settle(sync2_q, sync3_q, pin_q);
		end
	end

	// Wishbone slave: one-cycle answer, unmapped reads give zero.
	always @(posedge clk_in) begin
		if (rst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
			ctrl_q     <= `CTRL_RESET;
			cmd_q      <= 13'h0000;
			cmd_pend_q <= 1'b0;
		end else if (ce_in) begin
			wb_ack_out <= wb_req;
			wb_dat_out <= 32'h00000000;
			if (rst_q == R_SETUP)
				cmd_pend_q <= 1'b0;
			if (wb_req && wb_we_in) begin
				if (wb_adr_in == `OFS_CTRL && wb_sel_in[0])
					ctrl_q <= wb_dat_in[2:0];
				if (wb_adr_in == `OFS_REG_CMD &&
						wb_sel_in[1:0] == 2'h3 && !cmd_pend_q &&
						rst_q == R_IDLE) begin
					cmd_q      <= wb_dat_in[12:0];
					cmd_pend_q <= 1'b1;
				end
			end else if (wb_req) begin
				if (wb_adr_in == `OFS_CTRL)
					wb_dat_out <= {29'h0, ctrl_q};
				else if (wb_adr_in == `OFS_REG_CMD)
					wb_dat_out <= {19'h0, cmd_q};
				else if (wb_adr_in == `OFS_STATUS)
					wb_dat_out <= {13'h0, dir_s, ~dma_ack_n_out,
						owned, rdata_q, 7'h0,
						cmd_pend_q | (rst_q != R_IDLE)};
				else if (is_mem)
					wb_dat_out <= {24'h0, mem_q[mem_idx]};
			end
		end
	end

	// System memory shared by software and the DMA glue.
	always @(posedge clk_in) begin
		if (ce_in && !rst_in) begin
			if (dst_q == D_WR && if_ris)
				mem_q[addr_s[7:0]] <= data_s;
			else if (wb_req && wb_we_in && is_mem && wb_sel_in[0])
				mem_q[mem_idx] <= wb_dat_in[7:0];
		end
	end

	// Clock generation and modem loop gating.
	always @(posedge clk_in) begin
		if (rst_in) begin
			div_q                 <= 4'h0;
			cpu_clk_out           <= 1'b0;
			half_cpu_clk_out      <= 1'b0;
			if_clk_out            <= 1'b0;
			internal_loop_ctl_out <= 1'b0;
			modem_rts_n_out       <= 1'b1;
			dev_cts_n_out         <= 1'b1;
		end else if (ce_in) begin
			div_q <= wrap ? 4'h0 : div_q + 4'h1;
			if (wrap)
				cpu_clk_out <= ~cpu_clk_out;
			if (cpu_ris)
				half_cpu_clk_out <= ~half_cpu_clk_out;
			if (if_ris)
				if_clk_out <= 1'b1;
			else if (if_fal)
				if_clk_out <= 1'b0;
			internal_loop_ctl_out <= ctrl_q[`CTRL_LOOP_BIT];
			// Loop-back holds the modem off and returns RTS to CTS.
			modem_rts_n_out <= ctrl_q[`CTRL_LOOP_BIT] ? 1'b1
				: rts_s;
			dev_cts_n_out   <= ctrl_q[`CTRL_LOOP_BIT] ? rts_s
				: cts_s;
		end
	end

	// Request stages, processor ownership, and DMA cycle sequencing.
	always @(posedge clk_in) begin
		if (rst_in) begin
			request_stage1_n_out      <= 1'b1;
			request_stage2_n_out      <= 1'b1;
			request_stage3_n_out      <= 1'b1;
			cpu_bus_request_n_out     <= 1'b1;
			cpu_bus_grant_n_out       <= 1'b1;
			grant_delayed_n_out       <= 1'b1;
			cst_q                     <= C_RUN;
			dst_q                     <= D_IDLE;
			dma_ack_n_out             <= 1'b1;
			mem_output_en_n_out       <= 1'b1;
			mem_write_en_n_out        <= 1'b1;
			mem_decode_en_n_out       <= 1'b1;
			dma_mem_read_strobe_n_out <= 1'b1;
			addr_latch_drive_n_out    <= 1'b1;
			addr_cap_q                <= 16'h0000;
		end else if (ce_in) begin
			// Stage one follows the device request directly.
			request_stage1_n_out <= drq_s;
			// Later stages fall at once, rise on an interface edge.
			if (!request_stage1_n_out)
				request_stage2_n_out <= 1'b0;
			else if (if_ris)
				request_stage2_n_out <= 1'b1;
			if (!request_stage2_n_out)
				request_stage3_n_out <= 1'b0;
			else if (if_ris)
				request_stage3_n_out <= 1'b1;
			cpu_bus_request_n_out <= fast ? request_stage3_n_out
				: request_stage2_n_out;

			// Processor: sample at rise, float next rise, release at fall.
			case (cst_q)
			C_RUN: begin
				if (cpu_ris && !cpu_bus_request_n_out &&
						ctrl_q[`CTRL_DMAEN_BIT] && rst_q == R_IDLE &&
						!cmd_pend_q)
					cst_q <= C_SEEN;
			end
			C_SEEN: begin
				if (cpu_ris) begin
					cpu_bus_grant_n_out <= 1'b0;
					cst_q               <= C_HELD;
				end
			end
			C_HELD: begin
				if (if_ris && cpu_bus_request_n_out)
					cst_q <= C_REL;
			end
			C_REL: begin
				if (cpu_fal) begin
					cpu_bus_grant_n_out <= 1'b1;
					cst_q               <= C_RUN;
				end
			end
			default: cst_q <= C_RUN;
			endcase

			// Delayed grant: falls on the next interface rise after grant, rises at once.
			// Grant moves on a processor clock rise, so in fast mode the lag may be half an interface cycle.
			if (cpu_bus_grant_n_out)
				grant_delayed_n_out <= 1'b1;
			else if (if_ris)
				grant_delayed_n_out <= 1'b0;
			// Address latches drive only while the device owns the bus.
			addr_latch_drive_n_out <= grant_delayed_n_out;

			case (dst_q)
			D_IDLE: begin
				if (if_ris && !grant_delayed_n_out &&
						!cpu_bus_grant_n_out) begin
					dma_ack_n_out <= 1'b0;
					dst_q         <= D_ACK;
				end
			end
			D_ACK: begin
				if (if_ris && !dir_s) begin
					dma_mem_read_strobe_n_out <= 1'b0;
					mem_output_en_n_out       <= 1'b0;
					mem_decode_en_n_out       <= 1'b0;
					addr_cap_q                <= addr_s;
					dst_q                     <= D_IN;
				end else if (if_ris) begin
					mem_write_en_n_out  <= 1'b0;
					mem_decode_en_n_out <= 1'b0;
					dst_q               <= D_WR;
				end
			end
			D_IN: begin
				if (if_fal) begin
					dma_ack_n_out <= 1'b1;
					dst_q         <= D_DONE;
				end
			end
			D_WR: begin
				if (if_ris) begin
					mem_write_en_n_out <= 1'b1;
					dst_q              <= D_END;
				end
			end
			D_END: begin
				if (if_fal) begin
					dma_ack_n_out       <= 1'b1;
					mem_decode_en_n_out <= 1'b1;
					dst_q               <= D_DONE;
				end
			end
			D_DONE: begin
				// Read strobes end with the grant on the clock fall.
				if (cst_q == C_REL && cpu_fal) begin
					dma_mem_read_strobe_n_out <= 1'b1;
					mem_output_en_n_out       <= 1'b1;
					mem_decode_en_n_out       <= 1'b1;
					dst_q                     <= D_IDLE;
				end else if (cpu_bus_grant_n_out) begin
					dma_mem_read_strobe_n_out <= 1'b1;
					mem_output_en_n_out       <= 1'b1;
					mem_decode_en_n_out       <= 1'b1;
					dst_q                     <= D_IDLE;
				end
			end
			default: dst_q <= D_IDLE;
			endcase
		end
	end

	// Register access sequencer and data transceiver control.
	always @(posedge clk_in) begin
		if (rst_in) begin
			rst_q                   <= R_IDLE;
			rcnt_q                  <= 8'h00;
			rdata_q                 <= 8'h00;
			reg_index_lines_out     <= 4'h0;
			dev_select_n_out        <= 1'b1;
			reg_write_strobe_n_out  <= 1'b1;
			reg_read_strobe_n_out   <= 1'b1;
			cpu_data_lines_out      <= 8'h00;
			cpu_data_lines_oe_n_out <= 1'b1;
			xcvr_toward_cpu_n_out   <= 1'b1;
		end else if (ce_in) begin
			case (rst_q)
			R_IDLE: begin
				// Glue drives memory data to the device on DMA In.
				cpu_data_lines_out      <= mem_q[addr_cap_q[7:0]];
				cpu_data_lines_oe_n_out <= ~(dst_q == D_IN ||
					(dst_q == D_DONE && !mem_output_en_n_out));
				// DMA Out reverses the bus from acknowledge to its end.
				xcvr_toward_cpu_n_out   <= ~(dst_q == D_WR ||
					dst_q == D_END || (dst_q == D_ACK && dir_s));
				if (cmd_pend_q && cst_q == C_RUN &&
						cpu_bus_grant_n_out && dst_q == D_IDLE) begin
					reg_index_lines_out <=
						cmd_q[`CMD_INDEX_LSB+3:`CMD_INDEX_LSB];
					dev_select_n_out    <= 1'b0;
					cpu_data_lines_out  <=
						cmd_q[`CMD_DATA_LSB+7:`CMD_DATA_LSB];
					cpu_data_lines_oe_n_out <= cmd_q[`CMD_READ_BIT];
					xcvr_toward_cpu_n_out   <=
						~cmd_q[`CMD_READ_BIT];
					rcnt_q <= SETUP_CYC;
					rst_q  <= R_SETUP;
				end
			end
			R_SETUP: begin
				if (rcnt_q > 8'h01)
					rcnt_q <= rcnt_q - 8'h01;
				else begin
					// One strobe falls after index and select settle.
					reg_read_strobe_n_out  <=
						~cmd_q[`CMD_READ_BIT];
					reg_write_strobe_n_out <=
						cmd_q[`CMD_READ_BIT];
					rcnt_q <= STROBE_CYC;
					rst_q  <= R_STRB;
				end
			end
			R_STRB: begin
				if (rcnt_q > 8'h01)
					rcnt_q <= rcnt_q - 8'h01;
				else begin
					// Read data is taken while the strobe is still low.
					if (cmd_q[`CMD_READ_BIT])
						rdata_q <= data_s;
					reg_read_strobe_n_out  <= 1'b1;
					reg_write_strobe_n_out <= 1'b1;
					rst_q                  <= R_HOLD;
				end
			end
			R_HOLD: begin
				// Select and data hold one cycle past the strobe rise.
				dev_select_n_out        <= 1'b1;
				cpu_data_lines_oe_n_out <= 1'b1;
				xcvr_toward_cpu_n_out   <= 1'b1;
				rst_q                   <= R_IDLE;
			end
			default: rst_q <= R_IDLE;
			endcase
		end
	end

endmodule // host_bus_dma_glue
`default_nettype wire

// ===== tb/host_bus_dma_glue_sva.sv
`default_nettype none
module host_bus_dma_glue_sva (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic dma_ack_n_out,
	input wire logic cpu_bus_request_n_out,
	input wire logic cpu_bus_grant_n_out,
	input wire logic grant_delayed_n_out,
	input wire logic request_stage1_n_out,
	input wire logic request_stage2_n_out,
	input wire logic mem_output_en_n_out,
	input wire logic mem_write_en_n_out,
	input wire logic mem_decode_en_n_out,
	input wire logic dma_mem_read_strobe_n_out,
	input wire logic reg_write_strobe_n_out,
	input wire logic reg_read_strobe_n_out,
	input wire logic cpu_data_lines_oe_n_out,
	input wire logic dev_select_n_out,
	input wire logic xcvr_toward_cpu_n_out,
	input wire logic addr_latch_drive_n_out,
	input wire logic internal_loop_ctl_out,
	input wire logic modem_rts_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Reset and loop-back outputs.
	a_reset_idle:
		assert property ($fell(rst_in) |-> cpu_bus_request_n_out &&
			grant_delayed_n_out && mem_write_en_n_out &&
			mem_output_en_n_out && !internal_loop_ctl_out)
		else $error("active output after reset");
	a_loop_rts_off:
		assert property (internal_loop_ctl_out &&
			$past(internal_loop_ctl_out, 2) |-> modem_rts_n_out)
		else $error("modem rts on in loop test");
	// Memory strobes and transceiver direction.
	a_mem_read_path:
		assert property (!mem_output_en_n_out |->
			mem_write_en_n_out && !mem_decode_en_n_out)
		else $error("output enable without decode");
	a_read_strobe_oe:
		assert property (!dma_mem_read_strobe_n_out |-> !mem_output_en_n_out)
		else $error("dma read strobe without output enable");
	a_mem_write_path:
		assert property (!mem_write_en_n_out |->
			!mem_decode_en_n_out && !xcvr_toward_cpu_n_out)
		else $error("write enable path wrong");
	a_write_forward:
		assert property (!reg_write_strobe_n_out |-> xcvr_toward_cpu_n_out &&
			!cpu_data_lines_oe_n_out && !dev_select_n_out)
		else $error("register write bus wrong");
	a_read_reverse:
		assert property (!reg_read_strobe_n_out |-> !xcvr_toward_cpu_n_out &&
			cpu_data_lines_oe_n_out && !dev_select_n_out)
		else $error("register read bus wrong");
	// Ownership and DMA sequence.
	a_latch_owner:
		assert property (!addr_latch_drive_n_out |->
			!$past(cpu_bus_grant_n_out, 3))
		else $error("latches drive without grant");
	a_ack_after_grant:
		assert property ($fell(dma_ack_n_out) |->
			!grant_delayed_n_out && !cpu_bus_grant_n_out)
		else $error("ack before delayed grant");
	a_grant_lag:
		assert property ($fell(grant_delayed_n_out) |->
			!$past(cpu_bus_grant_n_out, 8))
		else $error("delayed grant too early");
	a_mwe_width:
		assert property ($fell(mem_write_en_n_out) |->
			!mem_write_en_n_out [*7])
		else $error("write enable too short");
	a_ack_end_out:
		assert property ($rose(mem_write_en_n_out) |->
			##[4:8] $rose(dma_ack_n_out))
		else $error("ack not released after write");
	a_stage_order:
		assert property ($rose(request_stage2_n_out) |->
			$past(request_stage1_n_out))
		else $error("stage two released early");
endmodule // host_bus_dma_glue_sva
`default_nettype wire

// ===== tb/link_ctl_model.sv
`default_nettype none
module link_ctl_model (
	input  wire logic        clk_in,
	input  wire logic [7:0]  host_dat_in,
	input  wire logic        host_oe_n_in,
	input  wire logic [3:0]  index_in,
	input  wire logic        select_n_in,
	input  wire logic        wr_strobe_n_in,
	input  wire logic        rd_strobe_n_in,
	input  wire logic        ack_n_in,
	output logic      [7:0]  bus_out,
	output logic             request_n_out,
	output logic             out_dir_out,
	output logic      [15:0] addr_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] regs [16];
	logic [7:0] drive_q = 8'h00;
	logic       dev_oe_q = 1'b0;
	logic [7:0] last_q = 8'h00;
	initial begin
		request_n_out = 1'b1;
		out_dir_out = 1'b0;
		addr_out = 16'hffff;
	end
	// Bus level; a released bus shows a pattern that changes every cycle.
	assign bus_out = !host_oe_n_in ? host_dat_in :
		(!select_n_in && !rd_strobe_n_in) ? regs[index_in] :
		dev_oe_q ? drive_q : ~last_q;
	always @(posedge clk_in) last_q <= bus_out;
	// The addressed register takes the bus as the write strobe rises.
	always @(posedge wr_strobe_n_in) begin
		if (!select_n_in) regs[index_in] <= bus_out;
	end
	// One DMA byte after lag + 1 clock cycles; got is the byte read in.
	task automatic dma(input logic out, input logic [15:0] a,
		input logic [7:0] d, input int lag, output logic [7:0] got);
		repeat (lag + 1) @(posedge clk_in);
		out_dir_out <= out;
		addr_out <= a;
		request_n_out <= 1'b0;
		do @(posedge clk_in); while (ack_n_in);
		request_n_out <= 1'b1;
		drive_q <= d;
		dev_oe_q <= out;
		do @(posedge clk_in); while (!ack_n_in);
		got = bus_out;
		dev_oe_q <= 1'b0;
		addr_out <= 16'hffff;
	endtask
endmodule // link_ctl_model
`default_nettype wire

// ===== tb/host_bus_dma_glue_bench.sv
`default_nettype none
`include "host_bus_dma_glue_defs.vh"
module host_bus_dma_glue_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in, rst_in, ce_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
	logic [11:0] wb_adr_in;
	logic [3:0] wb_sel_in, reg_index_lines_out;
	logic [31:0] wb_dat_in, wb_dat_out, q;
	logic [7:0] cpu_data_lines_in, cpu_data_lines_out, got;
	logic [15:0] dma_addr_lines_in;
	logic cpu_data_lines_oe_n_out, dev_select_n_out, reg_write_strobe_n_out;
	logic reg_read_strobe_n_out, dma_request_n_in, dma_out_dir_in;
	logic dma_ack_n_out, cpu_bus_request_n_out, cpu_bus_grant_n_out;
	logic grant_delayed_n_out, request_stage1_n_out, request_stage2_n_out;
	logic request_stage3_n_out, mem_output_en_n_out, mem_write_en_n_out;
	logic mem_decode_en_n_out, dma_mem_read_strobe_n_out, cpu_clk_out;
	logic addr_latch_drive_n_out, xcvr_toward_cpu_n_out, if_clk_out;
	logic internal_loop_ctl_out, half_cpu_clk_out, dev_rts_n_in;
	logic modem_cts_n_in, modem_rts_n_out, dev_cts_n_out;
	int n_errors, samples_checked, cycles;
	time t0;
	host_bus_dma_glue uut (.*);
	link_ctl_model dev (
		.clk_in         (clk_in),
		.host_dat_in    (cpu_data_lines_out),
		.host_oe_n_in   (cpu_data_lines_oe_n_out),
		.index_in       (reg_index_lines_out),
		.select_n_in    (dev_select_n_out),
		.wr_strobe_n_in (reg_write_strobe_n_out),
		.rd_strobe_n_in (reg_read_strobe_n_out),
		.ack_n_in       (dma_ack_n_out),
		.bus_out        (cpu_data_lines_in),
		.request_n_out  (dma_request_n_in),
		.out_dir_out    (dma_out_dir_in),
		.addr_out       (dma_addr_lines_in)
	);
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// A hang is cut short after far more cycles than the tests need.
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("compared %0d mismatched %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Classic single Wishbone cycle, held until ack is sampled.
	task automatic wb(input logic we, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do @(posedge clk_in); while (wb_ack_out !== 1'b1);
		r = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask
	// Device register access, then poll until busy clears.
	task automatic dev_reg(input logic rd, input logic [3:0] i,
		input logic [7:0] d);
		wb(1'b1, `OFS_REG_CMD, {19'h0, rd, i, d}, q);
		q = 32'h1;
		while (q[`ST_BUSY_BIT] !== 1'b0)
			wb(1'b0, `OFS_STATUS, 32'h0, q);
	endtask
	task automatic wait_free();
		do @(posedge clk_in); while (cpu_bus_grant_n_out !== 1'b1);
	endtask
	task automatic t_reset();
		chk("idle", 32'h3fe, {cpu_bus_request_n_out, grant_delayed_n_out,
			request_stage1_n_out, request_stage2_n_out, request_stage3_n_out,
			dma_ack_n_out, mem_output_en_n_out, mem_write_en_n_out,
			mem_decode_en_n_out, internal_loop_ctl_out});
		wb(1'b0, 12'h00c, 32'h0, q);
		chk("unmapped", 32'h0, q);
		$display("test reset done");
	endtask
	task automatic t_regs();
		dev_reg(1'b0, 4'h0, 8'ha5);
		dev_reg(1'b0, 4'hf, 8'h5a);
		chk("reg 0", 32'ha5, dev.regs[0]);
		chk("reg 15", 32'h5a, dev.regs[15]);
		dev_reg(1'b1, 4'hf, 8'h00);
		chk("read 15", 32'h5a, q[15:8]);
		dev_reg(1'b1, 4'h0, 8'h00);
		chk("read 0", 32'ha5, q[15:8]);
		$display("test regs done");
	endtask
	// DMA In then DMA Out in one clock mode; device prompt then slow.
	task automatic t_dma(input logic fast);
		wb(1'b1, `OFS_MEM_BASE + 12'h0dc,
			{24'h0, 8'h3c ^ {7'h0, fast}}, q);
		wb(1'b1, `OFS_CTRL, {29'h0, 1'b1, 1'b0, fast}, q);
		dev.dma(1'b0, 16'h1237, 8'h00, 0, got);
		chk("dma in", {24'h0, 8'h3c ^ {7'h0, fast}}, got);
		wait_free();
		dev.dma(1'b1, 16'h12c8, 8'h96 ^ {7'h0, fast}, 3, got);
		wait_free();
		wb(1'b0, `OFS_MEM_BASE + 12'h320, 32'h0, q);
		chk("dma out", {24'h0, 8'h96 ^ {7'h0, fast}}, q);
		@(posedge if_clk_out);
		t0 = $time;
		@(posedge if_clk_out);
		chk("if period", fast ? 32'd160 : 32'd80, 32'($time - t0));
		@(posedge cpu_clk_out);
		t0 = $time;
		@(posedge cpu_clk_out);
		chk("cpu period", 32'd80, 32'($time - t0));
		@(posedge half_cpu_clk_out);
		t0 = $time;
		@(posedge half_cpu_clk_out);
		chk("half period", 32'd160, 32'($time - t0));
		$display("test dma done");
	endtask
	task automatic t_loop();
		wb(1'b1, `OFS_CTRL, 32'h2, q);
		dev_rts_n_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		chk("loop", 32'h2, {modem_rts_n_out, dev_cts_n_out});
		wb(1'b1, `OFS_CTRL, 32'h0, q);
		repeat (10) @(posedge clk_in);
		chk("no loop", 32'h1, {modem_rts_n_out, dev_cts_n_out});
		dev_rts_n_in <= 1'b1;
		modem_cts_n_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		chk("cts path", 32'h2, {modem_rts_n_out, dev_cts_n_out});
		$display("test loop done");
	endtask
	initial begin
		n_errors = 0;
		samples_checked = 0;
		cycles = 0;
		rst_in = 1'b1;
		ce_in = 1'b1;
		wb_cyc_in = 1'b0;
		wb_stb_in = 1'b0;
		wb_we_in = 1'b0;
		wb_adr_in = 12'h000;
		wb_sel_in = 4'hf;
		wb_dat_in = 32'h0;
		dev_rts_n_in = 1'b1;
		modem_cts_n_in = 1'b1;
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_regs();
		t_dma(1'b0);
		t_dma(1'b1);
		t_loop();
		conclude();
	end
endmodule // host_bus_dma_glue_bench
bind host_bus_dma_glue host_bus_dma_glue_sva chk_sva (.*);
`default_nettype wire
